/* core/arf_flags.sv */
// How it works
// - Ready flag clears only on a last-result read, never on channel reads.
// - Last-result read with completion keeps ready only if data stored.
// - Channel read during a completion with done already set still sets ready.
// - Disable of another channel during completion still stores data, sets ready.
// - Status read during completion still updates the global overrun flag.
// - Completion while ready is still set raises the global overrun flag.
// - Channel read during completion does not block global overrun set.
// - Disable during completion still raises global and channel overrun flags when ready and that channel's done are set.
// - Status read clears channel overrun unless a coincident completion finds its channel done set.
// - Channel done clears on its own read or on last-result read.
// - Channel disabled mid-conversion never raises its done flag.
// - Channel read clears only that channel's done flag.
// - Sleep takes effect only after the next conversion completes.
//
// Implementation choices: register access over APB and the register addresses.
module arf_flags (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [arf_pkg::AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic conv_done, // Core: conversion end pulse
	input wire logic [arf_pkg::CHW-1:0] conv_chan, // Core: finished channel
	input wire logic [arf_pkg::DW-1:0] conv_data, // Core: result
	output logic conv_start, // Start pulse to core
	output logic sleep_en, // Core may power down
	output logic [arf_pkg::NCH-1:0] chan_en, // Channel enables to core
	output logic irq // Interrupt, level
);

	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic conv_start_q;
	logic mode_sleep_q;
	logic sleep_q;
	logic [arf_pkg::NCH-1:0] en_q;
	logic [arf_pkg::NCH-1:0] eoc_q;
	logic [arf_pkg::NCH-1:0] eoc_d;
	logic [arf_pkg::NCH-1:0] channel_overrun_flag_q;
	logic [arf_pkg::NCH-1:0] channel_overrun_flag_d;
	logic ready_q;
	logic ready_d;
	logic anyovr_q;
	logic anyovr_d;
	logic [arf_pkg::DW-1:0] last_q;
	logic [arf_pkg::CHW-1:0] last_ch_q;
	logic [arf_pkg::EVW-1:0] isr_q;
	logic [arf_pkg::EVW-1:0] isr_d;
	logic [arf_pkg::EVW-1:0] imr_q;
	logic [arf_pkg::EVW-1:0] ev;
	logic irq_q;
	logic [arf_pkg::DW-1:0] mem_rdata;
	logic fin;
	logic wr;
	logic rd;
	logic store;
	logic rd_last;
	logic rd_sr;
	logic rd_cdr;
	logic [arf_pkg::CHW-1:0] cdr_idx;
	logic [31:0] rmux;
	logic mapped;

	// Channel result register window test
	function automatic logic is_cdr(input logic [arf_pkg::AW-1:0] a);
		return (a & arf_pkg::A_CDR_MASK) == arf_pkg::A_CDR0;
	endfunction

	// Channel number from a result address
	function automatic logic [arf_pkg::CHW-1:0] cdr_of(
		input logic [arf_pkg::AW-1:0] a);
		return a[arf_pkg::CHW+1:2];
	endfunction

	// One-hot channel mask
	function automatic logic [arf_pkg::NCH-1:0] onehot(
		input logic [arf_pkg::CHW-1:0] c);
		return arf_pkg::NCH'(1) << c;
	endfunction

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign conv_start = conv_start_q;
	assign sleep_en = sleep_q;
	assign chan_en = en_q;
	assign irq = irq_q;

	// Access strobes, taken at the completing edge
	assign fin = psel & penable & pready_q;
	assign wr = fin & pwrite;
	assign rd = fin & ~pwrite;
	assign cdr_idx = cdr_of(paddr);
	assign rd_cdr = rd & is_cdr(paddr);
	assign rd_last = rd & (paddr == arf_pkg::A_LAST);
	assign rd_sr = rd & (paddr == arf_pkg::A_SR);

	// Completion is stored only on an enabled channel
	assign store = conv_done & en_q[conv_chan];

	// Result storage, addressed in the setup cycle
	arf_result_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.we(store),
		.waddr(conv_chan),
		.wdata(conv_data),
		.raddr(cdr_idx),
		.rdata_q(mem_rdata)
	);

	// Read multiplexer
	always_comb
	begin
		rmux = arf_pkg::ZERO32;
		mapped = 1'b1;
		if (is_cdr(paddr))
		begin
			rmux[arf_pkg::DW-1:0] = mem_rdata;
		end
		else
		begin
			unique case (paddr)
				arf_pkg::A_CTRL, arf_pkg::A_CHEN, arf_pkg::A_CHDIS: ;
				arf_pkg::A_MODE: rmux[arf_pkg::B_SLEEP] = mode_sleep_q;
				arf_pkg::A_CHSR: rmux[arf_pkg::NCH-1:0] = en_q;
				arf_pkg::A_SR:
				begin
					rmux[arf_pkg::B_EOC+:arf_pkg::NCH] = eoc_q;
					rmux[arf_pkg::B_CHANNEL_OVERRUN_FLAG+:arf_pkg::NCH] = channel_overrun_flag_q;
					rmux[arf_pkg::B_READY] = ready_q;
					rmux[arf_pkg::B_ANYOVR] = anyovr_q;
				end
				arf_pkg::A_LAST: rmux[arf_pkg::DW-1:0] = last_q;
				arf_pkg::A_ISR: rmux[arf_pkg::EVW-1:0] = isr_q;
				arf_pkg::A_IMR: rmux[arf_pkg::EVW-1:0] = imr_q;
				default: mapped = 1'b0;
			endcase
		end
	end

	// APB answer: one wait state, then ready with data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			prdata_q <= arf_pkg::ZERO32;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= psel & penable & ~pready_q;
			if (psel & penable & ~pready_q)
			begin
				prdata_q <= pwrite ? arf_pkg::ZERO32 : rmux;
				pslverr_q <= ~mapped;
			end
			else
			begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// Control registers and start pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_start_q <= 1'b0;
			mode_sleep_q <= 1'b0;
			en_q <= arf_pkg::ZERO_CH;
			imr_q <= arf_pkg::ZERO_EV;
		end
		else
		begin
			conv_start_q <= wr & (paddr == arf_pkg::A_CTRL)
				& pwdata[arf_pkg::B_START];
			if (wr & (paddr == arf_pkg::A_MODE))
			begin
				mode_sleep_q <= pwdata[arf_pkg::B_SLEEP];
			end
			if (wr & (paddr == arf_pkg::A_CHEN))
			begin
				en_q <= en_q | pwdata[arf_pkg::NCH-1:0];
			end
			else if (wr & (paddr == arf_pkg::A_CHDIS))
			begin
				en_q <= en_q & ~pwdata[arf_pkg::NCH-1:0];
			end
			if (wr & (paddr == arf_pkg::A_IMR))
			begin
				imr_q <= pwdata[arf_pkg::EVW-1:0];
			end
		end
	end

	// Sleep follows a completed conversion, never an idle request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sleep_q <= 1'b0;
		end
		else if (!mode_sleep_q)
		begin
			sleep_q <= 1'b0;
		end
		else if (conv_done)
		begin
			sleep_q <= 1'b1;
		end
	end

	// Next flag values; every set wins over a coincident clear
	always_comb
	begin
		eoc_d = eoc_q;
		if (rd_cdr)
		begin
			eoc_d = eoc_d & ~onehot(cdr_idx);
		end
		if (rd_last)
		begin
			eoc_d = eoc_d & ~onehot(last_ch_q);
		end
		if (store)
		begin
			eoc_d = eoc_d | onehot(conv_chan);
		end
		channel_overrun_flag_d = rd_sr ? arf_pkg::ZERO_CH : channel_overrun_flag_q;
		if (store & eoc_q[conv_chan])
		begin
			channel_overrun_flag_d = channel_overrun_flag_d | onehot(conv_chan);
		end
		// Channel reads never touch the ready flag
		ready_d = (ready_q & ~rd_last) | store;
		anyovr_d = (anyovr_q & ~rd_sr) | (store & ready_q);
	end

	// Status flags and last result
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			eoc_q <= arf_pkg::ZERO_CH;
			channel_overrun_flag_q <= arf_pkg::ZERO_CH;
			ready_q <= 1'b0;
			anyovr_q <= 1'b0;
			last_q <= arf_pkg::ZERO_DATA;
			last_ch_q <= '0;
		end
		else
		begin
			eoc_q <= eoc_d;
			channel_overrun_flag_q <= channel_overrun_flag_d;
			ready_q <= ready_d;
			anyovr_q <= anyovr_d;
			if (store)
			begin
				last_q <= conv_data;
				last_ch_q <= conv_chan;
			end
		end
	end

	// Interrupt events from flag rises
	always_comb
	begin
		ev = arf_pkg::ZERO_EV;
		ev[arf_pkg::B_EV_EOC+:arf_pkg::NCH] = eoc_d & ~eoc_q;
		ev[arf_pkg::B_EV_READY] = ready_d & ~ready_q;
		ev[arf_pkg::B_EV_CHANNEL_OVERRUN_FLAG] = |(channel_overrun_flag_d & ~channel_overrun_flag_q);
		ev[arf_pkg::B_EV_ANYOVR] = anyovr_d & ~anyovr_q;
		isr_d = isr_q;
		if (wr & (paddr == arf_pkg::A_ISR))
		begin
			isr_d = isr_d & ~pwdata[arf_pkg::EVW-1:0];
		end
		isr_d = isr_d | ev;
	end

	// Sticky event status and interrupt line
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			isr_q <= arf_pkg::ZERO_EV;
			irq_q <= 1'b0;
		end
		else
		begin
			isr_q <= isr_d;
			irq_q <= |(isr_d & imr_q);
		end
	end

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ready_keep_cdr: assert property (
		rd_cdr & !store |=> ready_q == $past(ready_q))
		else $error("ready flag changed by channel read");

	a_ready_on_store: assert property (
		store |=> ready_q)
		else $error("ready flag not set after stored result");

	a_ready_no_store: assert property (
		rd_last & !store |=> !ready_q)
		else $error("ready flag kept without stored data");

	a_anyovr_set: assert property (
		store & ready_q |=> anyovr_q)
		else $error("global overrun not raised");

	a_anyovr_event: assert property (
		store & ready_q & !anyovr_q |=> isr_q[arf_pkg::B_EV_ANYOVR])
		else $error("global overrun event not latched");

	a_anyovr_clear: assert property (
		rd_sr & !(store & ready_q) |=> !anyovr_q)
		else $error("global overrun not cleared by status read");

	a_channel_overrun_flag_clear: assert property (
		rd_sr & !store |=> channel_overrun_flag_q == arf_pkg::ZERO_CH)
		else $error("channel overrun not cleared by status read");

	a_channel_overrun_flag_stale: assert property (
		rd_sr & store & !eoc_q[conv_chan] |=> channel_overrun_flag_q == arf_pkg::ZERO_CH)
		else $error("channel overrun kept across status read");

	a_channel_overrun_flag_set: assert property (
		store & eoc_q[conv_chan] |=> channel_overrun_flag_q[$past(conv_chan)])
		else $error("channel overrun not raised");

	a_eoc_only_z: assert property (
		rd_cdr & !store & !rd_last
		|=> eoc_q == ($past(eoc_q) & ~onehot($past(cdr_idx))))
		else $error("wrong done flag cleared");

	a_eoc_disabled: assert property (
		conv_done & !en_q[conv_chan] & !eoc_q[conv_chan]
		|=> !eoc_q[$past(conv_chan)])
		else $error("done raised on disabled channel");

	a_sleep_wait: assert property (
		!sleep_q & !conv_done |=> !sleep_q)
		else $error("sleep entered without a conversion");

endmodule

/* core/arf_result_mem.sv */
// Per-channel result store, read data registered
module arf_result_mem (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic we, // Write strobe
	input wire logic [arf_pkg::CHW-1:0] waddr, // Write channel
	input wire logic [arf_pkg::DW-1:0] wdata, // Write data
	input wire logic [arf_pkg::CHW-1:0] raddr, // Read channel
	output logic [arf_pkg::DW-1:0] rdata_q // Registered read data
);

	logic [arf_pkg::DW-1:0] mem [arf_pkg::NCH];

	// Storage array, cleared so a never-written channel reads zero, not X
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < arf_pkg::NCH; i++)
			begin
				mem[i] <= arf_pkg::ZERO_DATA;
			end
		end
		else if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	// Read port register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_q <= arf_pkg::ZERO_DATA;
		end
		else
		begin
			rdata_q <= mem[raddr];
		end
	end

endmodule

/* include/arf_pkg.sv */
package arf_pkg;

	// Converter geometry
	localparam int NCH = 4;
	localparam int CHW = 2;
	localparam int DW = 10;
	localparam int AW = 8;
	localparam int EVW = 7;

	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_MODE = 8'h04;
	localparam logic [7:0] A_CHEN = 8'h10;
	localparam logic [7:0] A_CHDIS = 8'h14;
	localparam logic [7:0] A_CHSR = 8'h18;
	localparam logic [7:0] A_SR = 8'h1C;
	localparam logic [7:0] A_LAST = 8'h20;
	localparam logic [7:0] A_ISR = 8'h24;
	localparam logic [7:0] A_IMR = 8'h28;
	localparam logic [7:0] A_CDR0 = 8'h30;
	localparam logic [7:0] A_CDR_MASK = 8'hF0;

	// Field positions
	localparam int B_START = 0;
	localparam int B_SLEEP = 0;
	localparam int B_EOC = 0;
	localparam int B_CHANNEL_OVERRUN_FLAG = 8;
	localparam int B_READY = 16;
	localparam int B_ANYOVR = 17;
	localparam int B_EV_EOC = 0;
	localparam int B_EV_READY = 4;
	localparam int B_EV_CHANNEL_OVERRUN_FLAG = 5;
	localparam int B_EV_ANYOVR = 6;

	// Reset values
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [DW-1:0] ZERO_DATA = 10'h000;
	localparam logic [NCH-1:0] ZERO_CH = 4'h0;
	localparam logic [EVW-1:0] ZERO_EV = 7'h00;

endpackage

/* tb/arf_core_model.sv */
// Conversion core stand-in: bench-timed or start-triggered results
module arf_core_model #(
	parameter int LAT = 4
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic conv_start, // Start pulse from block
	input wire logic req, // Bench asks for a completion
	input wire logic [1:0] req_ch, // Channel for it
	input wire logic [9:0] req_d, // Result for it
	output logic conv_done, // End of conversion pulse
	output logic [1:0] conv_chan, // Finished channel
	output logic [9:0] conv_data // Result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	logic [1:0] ch_q;
	logic [9:0] d_q;
	// Started conversion finishes LAT cycles later on channel 0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 4'h0;
			conv_done <= 1'b0;
			ch_q <= 2'h0;
			d_q <= 10'h000;
		end
		else
		begin
			cnt_q <= conv_start ? 4'(LAT) : cnt_q - 4'(cnt_q != 0);
			conv_done <= req || cnt_q == 4'h1;
			if (req)
			begin
				ch_q <= req_ch;
				d_q <= req_d;
			end
			else if (cnt_q == 4'h1)
			begin
				ch_q <= 2'h0;
				d_q <= 10'h2A5;
			end
		end
	end
	// Stale values never look valid outside the pulse
	assign conv_chan = conv_done ? ch_q : ~ch_q;
	assign conv_data = conv_done ? d_q : ~d_q;
endmodule

/* tb/arf_flags_tb.sv */
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
module arf_flags_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SR = arf_pkg::A_SR;
	localparam logic [7:0] LST = arf_pkg::A_LAST;
	localparam logic [7:0] C0 = arf_pkg::A_CDR0;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, conv_done, conv_start, sleep_en, irq;
	logic [1:0] conv_chan;
	logic [9:0] conv_data;
	logic [3:0] chan_en;
	logic req = 0;
	logic [1:0] req_ch = 0;
	logic [9:0] req_d = 0;
	logic [32:0] note[$];
	logic [32:0] exp;
	logic [31:0] d[8];
	int err_count = 0, tests_run = 0, seed = 51;
	arf_flags i_arf_flags (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .conv_done, .conv_chan,
		.conv_data, .conv_start, .sleep_en, .chan_en, .irq);
	arf_core_model i_arf_core_model (.pclk, .presetn, .conv_start, .req,
		.req_ch, .req_d, .conv_done, .conv_chan, .conv_data);
	// Clock
	initial forever #10 pclk = ~pclk;
	// One transfer; f makes the core finish at the completing edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, input logic [32:0] e, input logic f,
		input logic [1:0] fc, input logic [31:0] fd);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		if (!w) note.push_back(e);
		@(posedge pclk);
		penable <= 1;
		req <= f;
		req_ch <= fc;
		req_d <= fd[9:0];
		do
		begin
			@(posedge pclk);
			req <= 0;
		end
		while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0, {1'b0, e}, 0, 0, 0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1, a, v, 0, 0, 0, 0);
	endtask
	task automatic cv(input logic [1:0] c, input logic [31:0] v);
		@(posedge pclk);
		req <= 1;
		req_ch <= c;
		req_d <= v[9:0];
		@(posedge pclk);
		req <= 0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic ck_irq(input logic e);
		repeat (2) @(posedge pclk);
		`CHK("irq", e, irq)
	endtask
	task automatic end_sim;
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Read results against the oldest note
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			exp = note.pop_front();
			`CHK("read", exp, {pslverr, prdata})
		end
	end
	// Watchdog
	initial
	begin
		#100us;
		err_count++;
		end_sim();
	end
	// Main sequence
	initial
	begin
		for (int i = 0; i < 8; i++)
			d[i] = {22'h0, 10'($random(seed))};
		repeat (12) @(posedge pclk);
		presetn <= 1;
		rd(arf_pkg::A_CHSR, 0);
		apb(0, 8'h0C, 0, {1'b1, 32'h0}, 0, 0, 0);
		wr(arf_pkg::A_CHEN, 32'h0000_000F);
		rd(arf_pkg::A_CHSR, 32'h0000_000F);
		cv(0, d[0]);
		cv(1, d[1]);
		rd(C0 + 8'h08, 0);
		rd(SR, 32'h0003_0003);
		rd(C0, d[0]);
		rd(SR, 32'h0001_0002);
		rd(LST, d[1]);
		rd(SR, 0);
		rd(arf_pkg::A_ISR, 32'h0000_0053);
		ck_irq(0);
		wr(arf_pkg::A_IMR, 32'h0000_0010);
		ck_irq(1);
		wr(arf_pkg::A_ISR, 32'h0000_007F);
		ck_irq(0);
		rd(arf_pkg::A_ISR, 0);
		cv(2, d[2]);
		cv(1, d[3]);
		rd(SR, 32'h0003_0006);
		apb(0, C0 + 8'h0C, 0, 0, 1, 2, d[4]);
		rd(SR, 32'h0003_0406);
		rd(SR, 32'h0001_0006);
		rd(LST, d[4]);
		rd(SR, 32'h0000_0002);
		wr(arf_pkg::A_CHDIS, 32'h0000_0008);
		rd(arf_pkg::A_CHSR, 32'h0000_0007);
		`CHK("chan_en", 4'h7, chan_en)
		apb(0, LST, 0, {1'b0, d[4]}, 1, 3, d[5]);
		rd(SR, 32'h0000_0002);
		apb(0, LST, 0, {1'b0, d[4]}, 1, 0, d[5]);
		rd(SR, 32'h0001_0003);
		apb(1, arf_pkg::A_CHDIS, 8, 0, 1, 0, d[6]);
		rd(C0, d[6]);
		rd(LST, d[6]);
		apb(0, SR, 0, {1'b0, 32'h0002_0102}, 1, 0, d[7]);
		rd(SR, 32'h0001_0003);
		apb(0, SR, 0, {1'b0, 32'h0001_0003}, 1, 2, d[0]);
		rd(SR, 32'h0003_0007);
		wr(arf_pkg::A_MODE, 32'h0000_0001);
		rd(arf_pkg::A_MODE, 32'h0000_0001);
		`CHK("sleep", 1'b0, sleep_en)
		wr(arf_pkg::A_CTRL, 32'h0000_0001);
		@(posedge pclk);
		`CHK("start", 1'b1, conv_start)
		for (int i = 0; i < 20 && sleep_en !== 1'b1; i++)
			@(posedge pclk);
		`CHK("sleep", 1'b1, sleep_en)
		end_sim();
	end
endmodule
